// [core/ifdb_defines.svh]
`ifndef IFDB_DEFINES_SVH
`define IFDB_DEFINES_SVH

// ==========================================================
// register map (byte offsets inside the unit)
`define IFDB_CTRL_OFFSET       8'h70
`define IFDB_STAT_OFFSET       8'h74
`define IFDB_GROUP_OFFSET      8'h80

// ==========================================================
// field layout of interrupt_debounce_control
`define IFDB_EN_LSB            0
`define IFDB_EN_MSB            3
`define IFDB_SEL_LSB           4
`define IFDB_SEL_MSB           7

// ==========================================================
// reset values
`define IFDB_CTRL_RESET        8'h00
`define IFDB_GROUP_RESET       32'h0000_0000
`define IFDB_CNT_RESET         15'h0000

// ==========================================================
// sizes and bus encodings
`define IFDB_LINES             4
`define IFDB_SEL_W             4
`define IFDB_SEL_SHORT_MAX     4'h8
`define IFDB_GRP_W             2
`define IFDB_OFFS_W            8
`define IFDB_HSIZE_WORD        3'h2
`define IFDB_HRESP_OKAY        1'h0
`define IFDB_WORD_ZERO         32'h0000_0000

`endif

// [core/ifdb_pkg.sv]
package ifdb_pkg;

  // ==========================================================
  // pending data phase of the register slave
  typedef enum logic [1:0] {
    IFDB_PH_IDLE  = 2'b00,
    IFDB_PH_WRITE = 2'b01,
    IFDB_PH_READ  = 2'b10
  } ifdb_phase_t;

endpackage : ifdb_pkg

// [core/ifdb_if.sv]
`timescale 1ns/100ps
`include "ifdb_defines.svh"

interface ifdb_if;
  logic                     tick;
  logic [`IFDB_LINES-1:0]   raw;
  logic [`IFDB_LINES-1:0]   level;

  modport filt (input tick, input raw, output level);
  modport ctl  (output tick, output raw, input level);
endinterface : ifdb_if

// [core/ifdb_filter.sv]
`timescale 1ns/100ps
`include "ifdb_defines.svh"

module ifdb_filter (
  input wire logic  hclk,
  input wire logic  hresetn,
  ifdb_if.filt      fio
);

  logic [`IFDB_LINES-1:0] sample_r;
  logic [`IFDB_LINES-1:0] sample_nxt;
  logic [`IFDB_LINES-1:0] level_r;
  logic [`IFDB_LINES-1:0] level_nxt;

  // ==========================================================
  // two-sample debounce
  always_comb begin
    sample_nxt = sample_r;
    level_nxt  = level_r;
    if (fio.tick) begin
      sample_nxt = fio.raw;
      for (int i = 0; i < `IFDB_LINES; i++) begin
        if (fio.raw[i] == sample_r[i]) begin
          level_nxt[i] = fio.raw[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_r <= '0;
      level_r  <= '0;
    end else begin
      sample_r <= sample_nxt;
      level_r  <= level_nxt;
    end
  end

  assign fio.level = level_r;

endmodule : ifdb_filter

// [core/ifdb_top.sv]
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "ifdb_defines.svh"

// Functional notes
// - codes 0..8 sample every 2^n bus clocks, 1 to 256.
// - codes 9..15 sample every 2^(n-8) times 256 clocks, up to 32768.
// - enable bit one routes its line through the sampling debounce filter.
// - enable bit zero forwards the raw line without sampling delay.
// - control register resets to zero: unfiltered, one-clock interval.
// - each pin joins one of four lines by its 2-bit group selector.

module ifdb_top #(
  parameter int NUM_PINS = 16,
  parameter int CNT_W    = 15
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [NUM_PINS-1:0]   pin_level,
  output logic      [`IFDB_LINES-1:0] irq_line
);

  // ==========================================================
  // helper functions
  function automatic logic [CNT_W-1:0] ifdb_mask(input logic [`IFDB_SEL_W-1:0] code);
    logic [CNT_W-1:0] one;
    logic [CNT_W-1:0] period;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    if (code <= `IFDB_SEL_SHORT_MAX) begin
      period = CNT_W'(one << code);
    end else begin
      period = CNT_W'((one << (code - `IFDB_SEL_SHORT_MAX)) << `IFDB_SEL_SHORT_MAX);
    end
    // the top code wraps the period to zero, which still yields the full mask
    return CNT_W'(period - one);
  endfunction : ifdb_mask

  function automatic logic [`IFDB_LINES-1:0] ifdb_group(
    input logic [NUM_PINS-1:0]              pins,
    input logic [NUM_PINS*`IFDB_GRP_W-1:0] sel
  );
    logic [`IFDB_LINES-1:0] acc;
    acc = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      acc[sel[p*`IFDB_GRP_W +: `IFDB_GRP_W]] = acc[sel[p*`IFDB_GRP_W +: `IFDB_GRP_W]] | pins[p];
    end
    return acc;
  endfunction : ifdb_group

  function automatic logic [31:0] ifdb_read(
    input logic [`IFDB_OFFS_W-1:0]          offs,
    input logic [7:0]                       ctrl,
    input logic [`IFDB_LINES-1:0]           lvl,
    input logic [NUM_PINS*`IFDB_GRP_W-1:0] grp
  );
    logic [31:0] word;
    word = `IFDB_WORD_ZERO;
    case (offs)
      `IFDB_CTRL_OFFSET: begin
        word[7:0] = ctrl;
      end
      `IFDB_STAT_OFFSET: begin
        word[`IFDB_LINES-1:0] = lvl;
      end
      `IFDB_GROUP_OFFSET: begin
        word[NUM_PINS*`IFDB_GRP_W-1:0] = grp;
      end
      default: begin
        word = `IFDB_WORD_ZERO;
      end
    endcase
    return word;
  endfunction : ifdb_read

  function automatic logic ifdb_wr_hit(
    input ifdb_pkg::ifdb_phase_t    ph,
    input logic [`IFDB_OFFS_W-1:0]  offs,
    input logic [`IFDB_OFFS_W-1:0]  reg_offs
  );
    return (ph == ifdb_pkg::IFDB_PH_WRITE) && (offs == reg_offs);
  endfunction : ifdb_wr_hit

  // ==========================================================
  // declarations
  ifdb_if fio ();

  ifdb_pkg::ifdb_phase_t            phase_r;
  ifdb_pkg::ifdb_phase_t            phase_nxt;
  logic [`IFDB_OFFS_W-1:0]          addr_r;
  logic [`IFDB_OFFS_W-1:0]          addr_nxt;
  logic [7:0]                       ctrl_r;
  logic [7:0]                       ctrl_nxt;
  logic [NUM_PINS*`IFDB_GRP_W-1:0]  group_r;
  logic [NUM_PINS*`IFDB_GRP_W-1:0]  group_nxt;
  logic [31:0]                      hrdata_r;
  logic [31:0]                      hrdata_nxt;
  logic [CNT_W-1:0]                 cnt_r;
  logic [CNT_W-1:0]                 cnt_nxt;
  logic [`IFDB_LINES-1:0]           line_r;
  logic [`IFDB_LINES-1:0]           line_nxt;
  logic                             take;
  logic                             take_word;
  logic                             wr_ctrl;
  logic                             wr_group;
  logic                             hreadyout_r;
  logic                             hreadyout_nxt;
  logic                             hresp_r;
  logic                             hresp_nxt;
  logic [`IFDB_LINES-1:0]           grouped;
  logic [`IFDB_LINES-1:0]           enable;
  logic [`IFDB_SEL_W-1:0]           interval;

  assign enable   = ctrl_r[`IFDB_EN_MSB:`IFDB_EN_LSB];
  assign interval = ctrl_r[`IFDB_SEL_MSB:`IFDB_SEL_LSB];

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // hready low means another slave still stalls its data phase
  assign take      = hsel && hready && htrans[1];
  // only whole words are taken; narrower accesses finish as no-ops
  assign take_word = take && (hsize == `IFDB_HSIZE_WORD);

  // ==========================================================
  // pending data phase and its address
  always_comb begin
    phase_nxt = ifdb_pkg::IFDB_PH_IDLE;
    addr_nxt  = addr_r;
    if (take_word) begin
      addr_nxt = haddr[`IFDB_OFFS_W-1:0];
      if (hwrite) begin
        phase_nxt = ifdb_pkg::IFDB_PH_WRITE;
      end else begin
        phase_nxt = ifdb_pkg::IFDB_PH_READ;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= ifdb_pkg::IFDB_PH_IDLE;
      addr_r  <= '0;
    end else begin
      phase_r <= phase_nxt;
      addr_r  <= addr_nxt;
    end
  end

  // write data lands one cycle after its address phase
  assign wr_ctrl  = ifdb_wr_hit(phase_r, addr_r, `IFDB_CTRL_OFFSET);
  assign wr_group = ifdb_wr_hit(phase_r, addr_r, `IFDB_GROUP_OFFSET);

  // ==========================================================
  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `IFDB_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // pin group selectors
  always_comb begin
    group_nxt = group_r;
    if (wr_group) begin
      group_nxt = hwdata[NUM_PINS*`IFDB_GRP_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group_r <= `IFDB_GROUP_RESET;
    end else begin
      group_r <= group_nxt;
    end
  end

  // ==========================================================
  // read data, held until the next read is taken
  always_comb begin
    hrdata_nxt = hrdata_r;
    if (take_word && !hwrite) begin
      // next values, so a read right after a write sees the new word
      hrdata_nxt = ifdb_read(haddr[`IFDB_OFFS_W-1:0], ctrl_nxt, fio.level, group_nxt);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= `IFDB_WORD_ZERO;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // ==========================================================
  // sample interval counter
  always_comb begin
    cnt_nxt = CNT_W'(cnt_r + {{(CNT_W-1){1'b0}}, 1'b1});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= `IFDB_CNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // the counter is not cleared on a code change, so the first
  // interval after a change may be shorter than the new period
  // power-of-two tick
  assign fio.tick = (cnt_r & ifdb_mask(interval)) == '0;

  // ==========================================================
  // line grouping and filter
  // pins join lines
  assign grouped = ifdb_group(pin_level, group_r);
  assign fio.raw = grouped;

  ifdb_filter u_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .fio     (fio)
  );

  always_comb begin
    for (int i = 0; i < `IFDB_LINES; i++) begin
      line_nxt[i] = enable[i] ? fio.level[i] : grouped[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_r <= '0;
    end else begin
      line_r <= line_nxt;
    end
  end

  // ==========================================================
  // bus response: no wait states and no error cases
  always_comb begin
    hreadyout_nxt = 1'b1;
    hresp_nxt     = `IFDB_HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= `IFDB_HRESP_OKAY;
    end else begin
      hreadyout_r <= hreadyout_nxt;
      hresp_r     <= hresp_nxt;
    end
  end

  // ==========================================================
  // outputs

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign irq_line  = line_r;

endmodule : ifdb_top

// [sim/ifdb_top_props.sv]
`timescale 1ns/100ps

module ifdb_top_props #(
  parameter int NUM_PINS = 16
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [NUM_PINS-1:0] pin_level,
  input wire logic [3:0]          irq_line
);
  // ====================
  // shadow of control and grouping, st_r counts clocks since control changed
  logic [7:0]            ctl_r, ctl_nxt, ofs_r, ofs_nxt;
  logic [2*NUM_PINS-1:0] grp_r, grp_nxt;
  logic [2:0]            st_r, st_nxt;
  logic                  wr_r, wr_nxt, rd_r, rd_nxt;
  logic [3:0]            g;
  always_comb begin
    wr_nxt  = hsel && hready && htrans[1] && hsize == 3'h2 && hwrite;
    rd_nxt  = hsel && hready && htrans[1] && hsize == 3'h2 && !hwrite;
    ofs_nxt = haddr[7:0];
    ctl_nxt = (wr_r && ofs_r == 8'h70) ? hwdata[7:0] : ctl_r;
    grp_nxt = (wr_r && ofs_r == 8'h80) ? hwdata[2*NUM_PINS-1:0] : grp_r;
    st_nxt  = (ctl_nxt != ctl_r) ? 3'h0 : ((st_r == 3'h7) ? 3'h7 : st_r + 3'h1);
    g       = 4'h0;
    for (int p = 0; p < NUM_PINS; p++) begin
      g[grp_r[2*p+:2]] = g[grp_r[2*p+:2]] | pin_level[p];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ctl_r, ofs_r, grp_r, st_r, wr_r, rd_r} <= '0;
    end else begin
      {ctl_r, ofs_r, grp_r, st_r, wr_r, rd_r} <= {ctl_nxt, ofs_nxt, grp_nxt, st_nxt, wr_nxt, rd_nxt};
    end
  end
  // ====================
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RAW_PATH: assert property (st_r > 3'h1 |-> ((irq_line ^ $past(g)) & ~ctl_r[3:0]) == 4'h0)
    else $error("unfiltered line does not follow its pins");
  AST_FILT_RISE: assert property (st_r > 3'h3 && ctl_r[0] && $rose(irq_line[0]) |-> $past(g[0], 2))
    else $error("filtered line rose without a high sample");
  AST_FILT_FALL: assert property (st_r > 3'h3 && ctl_r[0] && $fell(irq_line[0]) |-> !$past(g[0], 2))
    else $error("filtered line fell without a low sample");
  AST_SLOW_TICK: assert property (
    st_r > 3'h3 && ctl_r[0] && ctl_r[7:4] != 4'h0 && $changed(irq_line[0])
    |-> $past(irq_line[0]) == $past(irq_line[0], 2)) else $error("filtered line moved twice in a row");
  AST_WIDE_TICK: assert property (
    st_r > 3'h3 && ctl_r[0] && ctl_r[7:4] > 4'h8 && $changed(irq_line[0])
    |-> $past(irq_line[0]) == $past(irq_line[0], 3)) else $error("long interval line moved too soon");
  AST_READ_CTRL: assert property (rd_r && ofs_r == 8'h70 |-> hrdata == {24'h0, ctl_r})
    else $error("control read back wrong");
  AST_UNMAPPED: assert property (rd_r && !(ofs_r inside {8'h70, 8'h74, 8'h80}) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RESET_IRQ: assert property ($rose(hresetn) |-> irq_line == 4'h0)
    else $error("line high after reset");
  AST_BUS_OKAY: assert property (hreadyout && hresp == 1'b0)
    else $error("bus response not ready and okay");
  cover property (st_r > 3'h3 && ctl_r[0] && $rose(irq_line[0]));
  cover property (rd_r && ofs_r == 8'h70);
  cover property (st_r > 3'h1 && ctl_r[3:0] == 4'h0 && $changed(irq_line));
endmodule : ifdb_top_props

// [sim/ifdb_pin_model.sv]
`timescale 1ns/100ps

// ====================
// grouped port pins; bounce makes every pin chatter each clock
module ifdb_pin_model (
  input  wire logic        hclk,
  input  wire logic [15:0] want,
  input  wire logic        bounce,
  output logic      [15:0] pin_level = 16'h0
);
  logic [15:0] lvl_nxt;
  always_comb lvl_nxt = bounce ? ~pin_level : want;
  always @(posedge hclk) pin_level <= lvl_nxt;
endmodule : ifdb_pin_model

// [sim/irq_input_debounce_filter_bench.sv]
`timescale 1ns/100ps

module irq_input_debounce_filter_bench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, bounce = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, grp, rnd;
  logic [15:0] want = 16'h0, pin_level;
  logic [3:0]  irq_line, full, old;
  logic        hreadyout, hresp;
  int          miscompares = 0, checks = 0, seed = 32'hD9D0;
  always #5 hclk = ~hclk;
  ifdb_top u_ifdb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_level(pin_level), .irq_line(irq_line));
  ifdb_pin_model u_ifdb_pin_model (.hclk(hclk), .want(want), .bounce(bounce), .pin_level(pin_level));
  // ====================
  // model and compare
  function automatic logic [3:0] grouped(input logic [15:0] p, input logic [31:0] s);
    grouped = 4'h0;
    for (int i = 0; i < 16; i++) if (p[i]) grouped[s[2*i+:2]] = 1'b1;
  endfunction : grouped
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_irq(input logic [3:0] exp);
    chk({28'h0, irq_line}, {28'h0, exp});
  endtask : chk_irq
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // ====================
  // tests
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h70, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h7C, 32'h0);
    chk(rd, 32'h0);
    grp = $random(seed);
    bus(1'b1, 8'h80, grp);
    bus(1'b0, 8'h80, 32'h0);
    chk(rd, grp);
    rnd = $random(seed);
    bus(1'b1, 8'h70, rnd & 32'hFFFF_FFF0);
    bus(1'b0, 8'h70, 32'h0);
    chk(rd, rnd & 32'hF0);
    $display("test registers done");
    repeat (8) begin
      @(posedge hclk);
      rnd = $random(seed);
      want <= rnd[15:0];
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk_irq(grouped(rnd[15:0], grp));
    end
    @(posedge hclk);
    want <= 16'h0;
    full = grouped(16'hFFFF, grp);
    $display("test raw done");
    // long codes dominate the run time, so the top code is only written and read back
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 8'h70, {24'h0, c[3:0], 4'hF});
      bus(1'b0, 8'h70, 32'h0);
      chk(rd, {24'h0, c[3:0], 4'hF});
      if (c < 15) begin
        old = want[0] ? full : 4'h0;
        @(posedge hclk);
        want <= ~want;
        repeat (2 ** c + 2) @(posedge hclk);
        @(negedge hclk);
        chk_irq(old);
        repeat (2 ** c + 1) @(posedge hclk);
        @(negedge hclk);
        chk_irq(~old & full);
      end
      if (c == 0) begin
        @(posedge hclk);
        bounce <= 1'b1;
        repeat (20) @(posedge hclk);
        bounce <= 1'b0;
        @(negedge hclk);
        chk_irq(~old & full);
      end
    end
    // pins are unchanged since the last flip, so the filter levels have settled
    bus(1'b0, 8'h74, 32'h0);
    chk(rd, {28'h0, ~old & full});
    $display("test filter done");
    close_out();
  end
  initial begin
    #900000;
    miscompares++;
    close_out();
  end
endmodule : irq_input_debounce_filter_bench

bind ifdb_top ifdb_top_props #(.NUM_PINS(NUM_PINS)) u_ifdb_top_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_level(pin_level),
  .irq_line(irq_line));
